/* File: hw/edge_check_pkg.sv */
// shared constants and types for the edge window bit check receiver back end
package edge_check_pkg;

   // ***********************************************************************
   // register map (byte addresses, one aligned word each)
   // ***********************************************************************
   localparam int unsigned AXI_ADDR_W       = 4;
   localparam logic [3:0]  ADDR_OPERATING_CONFIG_REGISTER      = 4'h0;
   localparam logic [3:0]  ADDR_WINDOW      = 4'h4;
   localparam logic [3:0]  ADDR_STATUS      = 4'h8;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // ***********************************************************************
   // field layout and values after reset
   // ***********************************************************************
   localparam logic [11:0] OPERATING_CONFIG_REGISTER_RESET     = 12'h22c; // baud 0, 6 bits, sleep 11
   localparam logic [11:0] WINDOW_RESET     = 12'h398; // lower 14, upper 24
   localparam int unsigned BAUD_LSB         = 10;
   localparam int unsigned BITCHK_LSB       = 8;
   localparam int unsigned POUT_BIT         = 7;
   localparam int unsigned SLEEP_LSB        = 2;
   localparam int unsigned XSTD_BIT         = 1;
   localparam int unsigned XTEMP_BIT        = 0;
   localparam int unsigned LMIN_LSB         = 6;
   localparam int unsigned LMAX_LSB         = 0;

   // ***********************************************************************
   // timing, counted in base clocks or in extended clock ticks
   // ***********************************************************************
   localparam int unsigned CLK_PERIOD_NS    = 25;
   localparam logic [2:0]  XCLK_LAST_MAX    = 3'h7;   // range 0 divides by 8
   localparam int unsigned SLEEP_UNIT_CLKS  = 1024;
   localparam logic [4:0]  CHECKS_PER_STEP  = 5'h06;  // three bits, two edges each
   localparam logic [7:0]  STARTUP_TICKS    = 8'h40;
   localparam logic [5:0]  HOLD_IN_TICKS    = 6'h09;
   localparam logic [5:0]  HOLD_OUT_TICKS   = 6'h0a;
   localparam logic [7:0]  LOW_MAX_TICKS    = 8'h50;
   localparam logic [7:0]  OFF_LOW_TICKS    = 8'h60;
   localparam logic [7:0]  SYNC_TICKS       = 8'h08;
   localparam logic [7:0]  BIT_SAMPLE_TICKS = 8'h10;

   // ***********************************************************************
   // operating modes
   // ***********************************************************************
   typedef enum logic [2:0] {
      st_sleep    = 3'h0,
      st_startup  = 3'h1,
      st_check    = 3'h3,
      st_receive  = 3'h2,
      st_off_sync = 3'h6,
      st_off_bit  = 3'h7
   } mode_type;

endpackage : edge_check_pkg

/* File: hw/edge_window_bit_check_rx.sv */
// edge window bit check, receiving mode data path and off commands, AXI4-Lite registers
// Functional notes
// - in check mode, measure each edge interval against lower and upper bounds
// - two checks per bit; 0, 3, 6 or 9 bits give 0..18 checks
// - interval inside window continues; outside it returns to sleep
// - lower bound is lower word ticks; upper bound is upper word minus one
// - bounds resolve to one extended period; upper word accepts up to 63
// - lower word resets to 14, upper word to 24
// - demodulator ignored during startup; window counter ticks on extended clock
// - fail when counter reaches upper word, or edge arrives below lower word
// - all bits passed: enter receiving mode and drive data onto the pin
// - receiving mode holds until an explicit off command
// - demodulator sampled on extended clock; output changes only on its ticks
// - after each output edge hold the level for in or out window time
// - low time of the data output is capped above any valid low
// - off transfer has first bit one and returns to polling
// - a data pin off command issues exactly one sync pulse
// - after any off command the sleep period runs before startup
// - enable low keeps sleeping; sleep starts at its rise; zero restarts now
// - extended period is 8, 4, 2 or 1 base clocks for ranges 0..3
// - first bit one is off; otherwise the bit check returns to receiving mode
// - sleep lasts sleep word times extension times 1024 base clocks
`timescale 1ns/10ps
`default_nettype none
module edge_window_bit_check_rx #(
   parameter int unsigned SLEEP_UNIT = edge_check_pkg::SLEEP_UNIT_CLKS
) (
   // clock and reset
   input  wire logic                                  aclk,
   input  wire logic                                  aresetn,
   // AXI4-Lite write channels
   input  wire logic [edge_check_pkg::AXI_ADDR_W-1:0] awaddr,
   input  wire logic                                  awvalid,
   output logic                                       awready,
   input  wire logic [31:0]                           wdata,
   input  wire logic [3:0]                            wstrb,
   input  wire logic                                  wvalid,
   output logic                                       wready,
   output logic [1:0]                                 bresp,
   output logic                                       bvalid,
   input  wire logic                                  bready,
   // AXI4-Lite read channels
   input  wire logic [edge_check_pkg::AXI_ADDR_W-1:0] araddr,
   input  wire logic                                  arvalid,
   output logic                                       arready,
   output logic [31:0]                                rdata,
   output logic [1:0]                                 rresp,
   output logic                                       rvalid,
   input  wire logic                                  rready,
   // demodulator and host pins
   input  wire logic                                  dem_out,
   input  wire logic                                  enable_in,
   input  wire logic                                  data_in,
   output logic                                       data_o,
   output logic                                       data_oe,
   output logic                                       pout
);
   import edge_check_pkg::*;

   // ***********************************************************************
   // declarations
   // ***********************************************************************
   mode_type    state_ff;
   mode_type    nxt_state;
   logic [11:0] operating_config_register_ff;
   logic [11:0] window_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [1:0]  rresp_ff;
   logic [31:0] rdata_ff;
   logic        wr_fire;
   logic        rd_fire;
   logic        tick;
   logic        dem_sync_ff;
   logic        dem_prev_ff;
   logic        dem_edge;
   logic [5:0]  win_cnt_ff;
   logic        armed_ff;
   logic [4:0]  checks_ff;
   logic [4:0]  need_checks;
   logic        fail_lo;
   logic        fail_hi;
   logic        check_fail;
   logic        check_done;
   logic        data_lvl_ff;
   logic [5:0]  hold_cnt_ff;
   logic [5:0]  hold_need_ff;
   logic [7:0]  ee_cnt_ff;
   logic        out_toggle;
   logic        in_window;
   logic [7:0]  phase_cnt_ff;
   logic        off_go;
   logic [23:0] sleep_cnt_ff;
   logic [23:0] sleep_target;
   logic [5:0]  lim_min;
   logic [5:0]  lim_max;
   logic [1:0]  baud_range_select;

   // byte lanes 0 and 1 carry the twelve register bits
   function automatic logic [11:0] lane_merge(input logic [11:0] old_v, input logic [11:0] new_v,
                                              input logic [1:0] strb);
      lane_merge = {strb[1] ? new_v[11:8] : old_v[11:8], strb[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : lane_merge

   function automatic logic addr_known(input logic [AXI_ADDR_W-1:0] addr);
      addr_known = (addr == ADDR_OPERATING_CONFIG_REGISTER) || (addr == ADDR_WINDOW) || (addr == ADDR_STATUS);
   endfunction : addr_known

   // ***********************************************************************
   // register bus slave
   // ***********************************************************************
   // address and data are taken together; one answer at a time
   assign wr_fire = awvalid && wvalid && !bvalid_ff;
   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign rd_fire = arvalid && !rvalid_ff;
   assign arready = !rvalid_ff;
   assign rvalid  = rvalid_ff;
   assign rresp   = rresp_ff;
   assign rdata   = rdata_ff;

   // write response, held until bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= addr_known(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // read data, unmapped addresses answer zero with an error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= 32'h0;
      end else if (rd_fire) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            ADDR_OPERATING_CONFIG_REGISTER: rdata_ff <= {20'h0, operating_config_register_ff};
            ADDR_WINDOW: rdata_ff <= {20'h0, window_ff};
            ADDR_STATUS: rdata_ff <= {22'h0, checks_ff, data_oe, data_lvl_ff, state_ff};
            default:     rdata_ff <= 32'h0;
         endcase
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // operating configuration; a failed check drops the temporary extension
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operating_config_register_ff <= OPERATING_CONFIG_REGISTER_RESET;
      end else if (wr_fire && awaddr == ADDR_OPERATING_CONFIG_REGISTER) begin
         operating_config_register_ff <= lane_merge(operating_config_register_ff, wdata[11:0], wstrb[1:0]);
      end else if (check_fail) begin
         operating_config_register_ff[XTEMP_BIT] <= 1'b0;
      end
   end

   // window bounds, six bits each so the upper word can reach 63
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         window_ff <= WINDOW_RESET;
      end else if (wr_fire && awaddr == ADDR_WINDOW) begin
         window_ff <= lane_merge(window_ff, wdata[11:0], wstrb[1:0]);
      end
   end

   assign lim_min           = window_ff[LMIN_LSB +: 6];
   assign lim_max           = window_ff[LMAX_LSB +: 6];
   assign baud_range_select = operating_config_register_ff[BAUD_LSB +: 2];
   assign pout              = operating_config_register_ff[POUT_BIT];
   assign need_checks       = 5'(operating_config_register_ff[BITCHK_LSB +: 2] * CHECKS_PER_STEP);
   assign sleep_target      = 24'(operating_config_register_ff[SLEEP_LSB +: 5]) * 24'(SLEEP_UNIT)
                              * ((operating_config_register_ff[XSTD_BIT] || operating_config_register_ff[XTEMP_BIT]) ? 24'h8 : 24'h1);

   // ***********************************************************************
   // extended clock and demodulator sampling
   // ***********************************************************************
   xclk_tick_gen u_tick (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .baud_range_select (baud_range_select),
      .tick              (tick)
   );

   // sampling only on ticks keeps every data interval a whole number of periods
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dem_sync_ff <= 1'b1;
         dem_prev_ff <= 1'b1;
      end else if (tick) begin
         dem_sync_ff <= dem_out;
         dem_prev_ff <= dem_sync_ff;
      end
   end

   assign dem_edge = tick && (dem_sync_ff != dem_prev_ff);

   // ***********************************************************************
   // mode sequencing
   // ***********************************************************************
   assign fail_lo    = dem_edge && armed_ff && (win_cnt_ff < lim_min);
   assign fail_hi    = (win_cnt_ff >= lim_max);
   assign check_fail = (state_ff == st_check) && (fail_lo || fail_hi);
   assign check_done = (state_ff == st_check) && dem_edge && armed_ff && !fail_lo && !fail_hi
                       && (checks_ff + 5'h1 == need_checks);
   assign off_go     = (state_ff == st_receive) && !data_oe && data_in
                       && (phase_cnt_ff >= OFF_LOW_TICKS);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         st_sleep: begin
            if (sleep_cnt_ff >= sleep_target) nxt_state = st_startup;
         end
         st_startup: begin
            if (tick && phase_cnt_ff >= STARTUP_TICKS) nxt_state = st_check;
         end
         st_check: begin
            if (need_checks == 5'h0 || check_done) begin
               nxt_state = st_receive;
            end else if (check_fail) begin
               nxt_state = st_sleep;
            end
         end
         st_receive: begin
            if (off_go) nxt_state = st_off_sync;
         end
         st_off_sync: begin
            if (tick && phase_cnt_ff >= SYNC_TICKS - 8'h1) nxt_state = st_off_bit;
         end
         st_off_bit: begin
            // first transfer bit high is off; a register load is not served here
            if (tick && phase_cnt_ff >= BIT_SAMPLE_TICKS) begin
               nxt_state = data_in ? st_sleep : st_receive;
            end
         end
         default: nxt_state = st_sleep;
      endcase
      if (!enable_in) nxt_state = st_sleep;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= st_sleep;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // sleep counter is held clear while enable is low, so the period starts at its rise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_cnt_ff <= 24'h0;
      end else if (state_ff != st_sleep || !enable_in) begin
         sleep_cnt_ff <= 24'h0;
      end else if (sleep_cnt_ff < sleep_target) begin
         sleep_cnt_ff <= sleep_cnt_ff + 24'h1;
      end
   end

   // phase counter: startup, sync pulse, bit sample and host low time share it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_cnt_ff <= 8'h0;
      end else if (state_ff != nxt_state) begin
         phase_cnt_ff <= 8'h0;
      end else if (state_ff == st_receive && (data_oe || data_in)) begin
         phase_cnt_ff <= 8'h0;
      end else if (tick && phase_cnt_ff != 8'hff) begin
         phase_cnt_ff <= phase_cnt_ff + 8'h1;
      end
   end

   // ***********************************************************************
   // bit check
   // ***********************************************************************
   // the first edge only arms the measurement, since the start of the interval is unknown
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_cnt_ff <= 6'h0;
         armed_ff   <= 1'b0;
         checks_ff  <= 5'h0;
      end else if (state_ff != st_check) begin
         win_cnt_ff <= 6'h0;
         armed_ff   <= 1'b0;
         checks_ff  <= 5'h0;
      end else if (dem_edge) begin
         win_cnt_ff <= 6'h0;
         armed_ff   <= 1'b1;
         if (armed_ff) checks_ff <= checks_ff + 5'h1;
      end else if (tick && win_cnt_ff != 6'h3f) begin
         win_cnt_ff <= win_cnt_ff + 6'h1;
      end
   end

   // ***********************************************************************
   // receiving mode data output
   // ***********************************************************************
   assign in_window  = (ee_cnt_ff >= {2'h0, lim_min}) && (ee_cnt_ff < {2'h0, lim_max});
   assign out_toggle = tick && (hold_cnt_ff >= hold_need_ff)
                       && ((dem_sync_ff != data_lvl_ff) || (!data_lvl_ff && ee_cnt_ff >= LOW_MAX_TICKS));

   // debounce: each output level lasts at least the hold time; a shorter spike during the hold is dropped, one after it reaches the pin stretched to it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_lvl_ff  <= 1'b1;
         hold_cnt_ff  <= HOLD_OUT_TICKS;
         hold_need_ff <= HOLD_OUT_TICKS;
         ee_cnt_ff    <= 8'h0;
      end else if (state_ff != st_receive) begin
         data_lvl_ff  <= 1'b1;
         hold_cnt_ff  <= HOLD_OUT_TICKS;
         hold_need_ff <= HOLD_OUT_TICKS;
         ee_cnt_ff    <= 8'h0;
      end else if (out_toggle) begin
         data_lvl_ff  <= !data_lvl_ff;
         hold_cnt_ff  <= 6'h0;
         hold_need_ff <= in_window ? HOLD_IN_TICKS : HOLD_OUT_TICKS;
         ee_cnt_ff    <= 8'h0;
      end else if (tick) begin
         if (hold_cnt_ff != 6'h3f) hold_cnt_ff <= hold_cnt_ff + 6'h1;
         if (ee_cnt_ff != 8'hff) ee_cnt_ff <= ee_cnt_ff + 8'h1;
      end
   end

   // open drain: only ever pull low, for data low or the sync pulse
   assign data_o  = 1'b0;
   assign data_oe = (state_ff == st_receive && !data_lvl_ff) || (state_ff == st_off_sync);

   // ***********************************************************************
   // assertions
   // ***********************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sync_begin;
      (state_ff == st_receive) ##1 (state_ff == st_off_sync);
   endsequence

   sequence s_sync_end;
      (state_ff == st_off_sync) ##1 (state_ff != st_off_sync);
   endsequence

   a_fail_low_edge: assert property (state_ff == st_check && fail_lo && enable_in |=> state_ff == st_sleep)
      else $error("early edge did not end the bit check");
   a_fail_upper: assert property (state_ff == st_check && win_cnt_ff >= lim_max && need_checks != 5'h0
                                  |=> state_ff == st_sleep)
      else $error("counter at upper word did not end the bit check");
   a_counter_restart: assert property (state_ff == st_check && dem_edge |=> win_cnt_ff == 6'h0)
      else $error("window counter not restarted at edge");
   a_receive_stays: assert property (state_ff == st_receive && enable_in && !off_go |=> state_ff == st_receive)
      else $error("receiving mode left without off command");
   a_output_on_tick: assert property (state_ff == st_receive && $changed(data_lvl_ff) && $past(state_ff) == st_receive
                                      |-> $past(tick))
      else $error("data output changed off an extended clock tick");
   a_hold_kept: assert property ($past(state_ff) == st_receive && state_ff == st_receive && $changed(data_lvl_ff)
                                 |-> $past(hold_cnt_ff) >= $past(hold_need_ff))
      else $error("data level changed before hold time");
   a_low_capped: assert property (state_ff == st_receive && !data_lvl_ff |-> ee_cnt_ff <= LOW_MAX_TICKS)
      else $error("data output low beyond its limit");
   a_sync_drive: assert property (s_sync_begin |-> data_oe)
      else $error("sync pulse not driven after off request");
   a_sync_single: assert property (s_sync_end |-> state_ff != st_off_sync ##1 state_ff != st_off_sync)
      else $error("second sync pulse issued");
   a_off_to_sleep: assert property (state_ff == st_off_bit && tick && phase_cnt_ff >= BIT_SAMPLE_TICKS && data_in
                                    |=> state_ff == st_sleep)
      else $error("off command did not return to sleep");
   a_enable_sleep: assert property (!enable_in |=> state_ff == st_sleep && sleep_cnt_ff == 24'h0)
      else $error("enable low did not hold sleep");
   a_check_entry: assert property (state_ff == st_check && check_done && enable_in |=> state_ff == st_receive)
      else $error("passed bit check did not enter receiving mode");

endmodule : edge_window_bit_check_rx
`default_nettype wire

/* File: hw/xclk_tick_gen.sv */
// extended clock tick generator, one base clock wide pulse per extended period
`timescale 1ns/10ps
`default_nettype none
module xclk_tick_gen (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // divider setting
   input  wire logic [1:0] baud_range_select,
   // tick out
   output logic            tick
);
   import edge_check_pkg::*;

   logic [2:0] div_cnt_ff;
   logic [2:0] last_count;

   // ranges 0..3 give periods of 8, 4, 2 and 1 base clocks
   assign last_count = XCLK_LAST_MAX >> baud_range_select;
   assign tick       = (div_cnt_ff >= last_count);

   // a shorter period taking effect mid count ends the period at once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_ff <= 3'h0;
      end else if (tick) begin
         div_cnt_ff <= 3'h0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 3'h1;
      end
   end

endmodule : xclk_tick_gen
`default_nettype wire

/* File: verif/edge_window_bit_check_rx_tb.sv */
// bench for the edge window bit check receiver
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: %h not %h", $time, a, b); end end
module edge_window_bit_check_rx_tb;
   import edge_check_pkg::*;
   typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [3:0] s; logic [1:0] rs; logic [31:0] x;} row_type;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, data_in, enable_in, data_o, data_oe, pout;
   logic dem_out = 1, pull_low = 0, doze = 0;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, r;
   int err_total = 0, n_tests = 0, cyc = 0, gap = 0, dcnt = 0, hi;
   row_type rows [9] = '{
      '{0, 4'h0, 0, 0, RESP_OKAY, 32'h22c}, '{0, 4'h4, 0, 0, RESP_OKAY, 32'h398},
      '{0, 4'hc, 0, 0, RESP_SLVERR, 0}, '{1, 4'h4, 32'h294, 4'h3, RESP_OKAY, 0},
      '{1, 4'h4, 32'h0ff, 4'h1, RESP_OKAY, 0}, '{0, 4'h4, 0, 0, RESP_OKAY, 32'h2ff},
      '{1, 4'h4, 32'h294, 4'h3, RESP_OKAY, 0}, '{1, 4'h0, 32'hd80, 4'h3, RESP_OKAY, 0},
      '{0, 4'h0, 0, 0, RESP_OKAY, 32'hd80}};
   host_mcu_model host (.data_o(data_o), .data_oe(data_oe), .pull_low(pull_low), .doze(doze),
      .data_in(data_in), .enable_in(enable_in));
   edge_window_bit_check_rx #(.SLEEP_UNIT(4)) dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .dem_out(dem_out), .enable_in(enable_in),
      .data_in(data_in), .data_o(data_o), .data_oe(data_oe), .pout(pout));
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   // demodulator stand-in: toggles every gap cycles, idles high when gap is zero
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (gap != 0) begin
         dcnt <= (dcnt + 1 >= gap) ? 0 : dcnt + 1;
         if (dcnt + 1 >= gap) dem_out <= ~dem_out;
      end else begin
         dem_out <= 1'b1;
      end
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 0; wvalid <= 0;
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp; bready <= 0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata; r = rresp; rready <= 0;
   endtask : rd
   task automatic wait_st(input logic [2:0] s);
      for (int i = 0; i < 300; i++) begin
         rd(ADDR_STATUS);
         if (d[2:0] === s) break;
      end
   endtask : wait_st
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].s);
         else rd(rows[i].a);
         `CHK(r, rows[i].rs)
         if (!rows[i].w) `CHK(d, rows[i].x)
      end
      `CHK(pout, 1'b1)
      // steady in-window edges pass six checks, then noise must not leave receive
      gap = 15;
      wait_st(st_receive);
      `CHK(d[2:0], st_receive)
      gap = 3;
      repeat (200) @(posedge aclk);
      rd(ADDR_STATUS);
      `CHK(d[2:0], st_receive)
      // enable low holds sleep; its rise restarts at once with sleep word zero
      doze <= 1;
      repeat (100) @(posedge aclk);
      rd(ADDR_STATUS);
      `CHK(d[2:0], st_sleep)
      doze <= 0;
      wait_st(st_startup);
      `CHK(d[2:0], st_startup)
      gap = 15;
      wait_st(st_receive);
      // off through the data pin: high idle level, long low, then one sync pulse
      gap = 0;
      repeat (20) @(posedge aclk);
      pull_low <= 1;
      repeat (100) @(posedge aclk);
      pull_low <= 0;
      hi = 0;
      repeat (40) @(posedge aclk) hi += data_oe;
      `CHK(hi, int'(SYNC_TICKS))
      wait_st(st_startup);
      `CHK(d[2:0], st_startup)
      // too short, then too long intervals must never reach receive
      for (int k = 0; k < 2; k++) begin
         gap = (k != 0) ? 30 : 5;
         repeat (600) @(posedge aclk);
         rd(ADDR_STATUS);
         `CHK(d[2:0] == st_receive, 1'b0)
      end
      // mid-run reset with a quiet demodulator: sleep 11 x 4 clocks, startup 65 ticks of 8 clocks,
      // then a check that sees no edge must time out at the upper word 24
      gap = 0;
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      `CHK(pout, 1'b0)
      repeat (38) @(posedge aclk);
      rd(ADDR_STATUS);
      `CHK(d[2:0], st_sleep)
      repeat (8) @(posedge aclk);
      rd(ADDR_STATUS);
      `CHK(d[2:0], st_startup)
      repeat (526) @(posedge aclk);
      rd(ADDR_STATUS);
      `CHK(d[2:0], st_check)
      repeat (180) @(posedge aclk);
      rd(ADDR_STATUS);
      `CHK(d[2:0], st_sleep)
      rd(ADDR_OPERATING_CONFIG_REGISTER);
      `CHK(d, 32'(OPERATING_CONFIG_REGISTER_RESET))
      rd(ADDR_WINDOW);
      `CHK(d, 32'(WINDOW_RESET))
      end_sim();
   end
endmodule : edge_window_bit_check_rx_tb
`default_nettype wire

/* File: verif/host_mcu_model.sv */
// host model: open-drain data wire with pull-up, enable pin driver
`timescale 1ns/10ps
`default_nettype none
module host_mcu_model (
   // device side
   input  wire logic data_o,
   input  wire logic data_oe,
   // commands from the bench
   input  wire logic pull_low,
   input  wire logic doze,
   // resolved pins
   output logic      data_in,
   output logic      enable_in
);
   // wired-and; the pull-up gives a one when nobody pulls, so off reads one
   assign data_in   = !(data_oe && !data_o) && !pull_low;
   assign enable_in = !doze;
endmodule : host_mcu_model
`default_nettype wire
